//--- bench/npic_core_model.sv
// Core stack model: keeps pushed bytes and answers a pop with the saved CC
`timescale 1ns/1ns
`default_nettype none
module npic_core_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Stack port
	input wire logic stack_push,
	input wire logic stack_pop,
	input wire logic [7:0] stack_wdata,
	output var logic stack_valid,
	output var logic [7:0] stack_rdata
);
	logic [7:0] mem [0:63];
	logic [5:0] sp_q;
	// Push stores one byte, pop returns the last byte of the frame
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sp_q <= 6'h00;
			stack_valid <= 1'b0;
			stack_rdata <= 8'h00;
		end else begin
			stack_valid <= stack_pop;
			if (stack_push) begin
				mem[sp_q] <= stack_wdata;
				sp_q <= sp_q + 6'h01;
			end
			if (stack_pop) begin
				stack_rdata <= mem[sp_q - 6'h01];
				sp_q <= sp_q - 6'h05;
			end else begin
				stack_rdata <= ~stack_rdata; // Stale data never looks valid
			end
		end
	end
endmodule
`default_nettype wire

//--- bench/npic_ctrl_asserts.sv
// Checker for service entry, return and masking of the controller
`timescale 1ns/1ns
`default_nettype none
module npic_ctrl_asserts (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Core strobes
	input wire logic insn_boundary,
	input wire logic trap_insn,
	input wire logic return_from_isr,
	input wire logic halt_req,
	input wire logic wait_req,
	input wire logic cpu_halted,
	input wire logic cpu_waiting,
	input wire logic cpu_stall,
	// Stack and vector
	input wire logic stack_valid,
	input wire logic [7:0] stack_rdata,
	input wire logic stack_push,
	input wire logic stack_pop,
	input wire logic pc_load,
	input wire logic [15:0] pc_vector,
	input wire logic [7:0] condition_code_reg
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_SEQ: assert property ($rose(cpu_stall) && !cpu_halted && !cpu_waiting
		|=> (stack_push[*5] ##1 pc_load) or stack_pop)
		else $error("entry or return sequence wrong");
	AST_PUSH_STALL: assert property (stack_push |-> cpu_stall)
		else $error("push while core runs");
	AST_LOAD_RUN: assert property (pc_load |-> !cpu_stall)
		else $error("stall held at vector load");
	AST_VEC: assert property (pc_load |-> !pc_vector[0] && pc_vector[15:5] == 11'h7ff)
		else $error("vector outside top region");
	AST_NMI_CC: assert property (pc_load && pc_vector[15:2] == 14'h3fff
		|-> condition_code_reg[5] && condition_code_reg[3])
		else $error("trap or reset not level 3");
	AST_RST: assert property ($rose(rst_n) |=> pc_load && pc_vector == 16'hfffe)
		else $error("no reset vector");
	AST_POP: assert property ($rose(stack_valid)
		|=> condition_code_reg == $past(stack_rdata) && !cpu_stall)
		else $error("CC not restored on return");
	AST_ONE: assert property (pc_load |=> !pc_load)
		else $error("vector load longer than one cycle");
	AST_MASK: assert property (insn_boundary && !trap_insn && !return_from_isr && !halt_req
		&& !wait_req && !cpu_halted && !cpu_stall && condition_code_reg[5]
		&& condition_code_reg[3] |=> !cpu_stall)
		else $error("maskable taken at level 3");
endmodule
bind npic_ctrl npic_ctrl_asserts u_chk (.mclk, .rst_n, .insn_boundary, .trap_insn,
	.return_from_isr, .halt_req, .wait_req, .cpu_halted, .cpu_waiting, .cpu_stall,
	.stack_valid, .stack_rdata,
	.stack_push, .stack_pop, .pc_load, .pc_vector, .condition_code_reg);
`default_nettype wire

//--- bench/npic_ctrl_bench.sv
// Testbench for the nested priority interrupt controller
`timescale 1ns/1ns
`default_nettype none
`include "npic_regs.vh"
module npic_ctrl_bench;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] ext_a = 8'hff;
	logic [7:0] rdata, srd, swd, cc;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic bnd = 1'b0;
	logic trap = 1'b0;
	logic ret = 1'b0;
	logic lowp = 1'b0;
	logic wt = 1'b0;
	logic [13:0] flag = 14'h0;
	logic [13:0] en = 14'h0;
	logic [13:0] clr = 14'h0;
	logic [15:0] pc = 16'h1234;
	logic [15:0] pcv;
	logic sv, spush, spop, pcl, stall, hlt, wtg;
	int mismatches = 0;
	int total_checks = 0;
	int n;
	// Clock of 40 ns
	always #20 mclk = ~mclk;
	npic_ctrl dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .ext_pins_a(ext_a),
		.ext_pins_b(ext_a), .periph_flag(flag), .periph_en(en), .periph_clear(clr),
		.insn_boundary(bnd), .trap_insn(trap), .return_from_isr(ret), .halt_req(lowp),
		.wait_req(wt), .program_counter(pc), .cpu_x(pc[15:8]), .cpu_a(pc[7:0]),
		.stack_valid(sv), .stack_rdata(srd), .stack_push(spush), .stack_pop(spop),
		.stack_wdata(swd), .pc_load(pcl), .pc_vector(pcv), .cpu_stall(stall),
		.cpu_halted(hlt), .cpu_waiting(wtg), .condition_code_reg(cc));
	npic_core_model core (.mclk(mclk), .rst_n(rst_n), .stack_push(spush),
		.stack_pop(spop), .stack_wdata(swd), .stack_valid(sv), .stack_rdata(srd));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		chk("reg_rdata", {8'h00, exp}, {8'h00, rdata});
	endtask
	// One instruction boundary, optionally with trap or return
	task automatic step(input logic t, input logic r);
		@(posedge mclk);
		bnd <= 1'b1;
		trap <= t;
		ret <= r;
		@(posedge mclk);
		bnd <= 1'b0;
		trap <= 1'b0;
		ret <= 1'b0;
	endtask
	task automatic take(input logic [15:0] vec, input logic [1:0] lvl);
		n = 0;
		while (pcl !== 1'b1 && n < 40) begin
			@(negedge mclk);
			n++;
		end
		chk("pc_vector", vec, pcv);
		chk("cc_prio", {14'h0, lvl}, {14'h0, cc[5], cc[3]});
	endtask
	task automatic idle(input int c);
		repeat (c) @(negedge mclk);
		chk("cpu_stall", 16'h0000, {15'h0, stall});
	endtask
	task automatic report_and_stop;
		$display("Checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (3000) @(posedge mclk);
		mismatches++;
		report_and_stop;
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		rd(`NPIC_ADDR_CC, `NPIC_CC_RST);
		rd(4'hf, 8'h00);
		wr(`NPIC_ADDR_PRIO0, 8'h64);
		rd(`NPIC_ADDR_PRIO0, 8'h74);
		$display("Test registers done");
		wr(`NPIC_ADDR_CC, 8'he2);
		flag[3] <= 1'b1;
		step(1'b0, 1'b0);
		idle(8);
		@(posedge mclk);
		en[3] <= 1'b1;
		idle(4);
		step(1'b0, 1'b0);
		take(16'hfff4, `NPIC_LVL1);
		@(posedge mclk);
		flag[2] <= 1'b1;
		en[2] <= 1'b1;
		step(1'b0, 1'b0);
		take(16'hfff6, `NPIC_LVL3);
		@(posedge mclk);
		clr[2] <= 1'b1;
		flag[2] <= 1'b0;
		@(posedge mclk);
		clr[2] <= 1'b0;
		step(1'b0, 1'b1);
		idle(12);
		chk("cc_return", 16'h00ca, {8'h00, cc});
		$display("Test nesting done");
		step(1'b1, 1'b0);
		take(`NPIC_VEC_TRAP, `NPIC_LVL3);
		step(1'b0, 1'b0);
		idle(8);
		wr(`NPIC_ADDR_CC, 8'he2);
		step(1'b0, 1'b0);
		take(16'hfff4, `NPIC_LVL1);
		$display("Test trap and pending done");
		@(posedge mclk);
		en[3] <= 1'b0;
		clr[3] <= 1'b1;
		@(posedge mclk);
		clr[3] <= 1'b0;
		rd(`NPIC_ADDR_PEN_HI, 8'h00);
		wr(`NPIC_ADDR_SENSE, 8'h01);
		wr(`NPIC_ADDR_GRPEN, 8'h03);
		lowp <= 1'b1;
		step(1'b0, 1'b0);
		lowp <= 1'b0;
		@(negedge mclk);
		chk("cpu_halted", 16'h0001, {15'h0, hlt});
		rd(`NPIC_ADDR_STAT, 8'h02);
		@(posedge mclk);
		ext_a <= 8'hfc;
		repeat (6) @(negedge mclk);
		chk("cpu_halted", 16'h0000, {15'h0, hlt});
		rd(`NPIC_ADDR_PEN_HI, 8'h01);
		step(1'b0, 1'b0);
		take(16'hfffa, `NPIC_LVL2);
		rd(`NPIC_ADDR_PEN_HI, 8'h00);
		$display("Test external and halt done");
		wt <= 1'b1;
		step(1'b0, 1'b0);
		wt <= 1'b0;
		@(negedge mclk);
		chk("cpu_waiting", 16'h0001, {15'h0, wtg});
		@(posedge mclk);
		flag[2] <= 1'b1;
		en[2] <= 1'b1;
		repeat (3) @(negedge mclk);
		chk("cpu_waiting", 16'h0000, {15'h0, wtg});
		step(1'b0, 1'b0);
		take(16'hfff6, `NPIC_LVL3);
		$display("Test wait done");
		report_and_stop;
	end
endmodule
`default_nettype wire

//--- hw/npic_ctrl.v
// Nested priority interrupt controller with stacking sequencer
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "npic_regs.vh"
module npic_ctrl #(
	parameter NVEC = 14
) (
	// Clock and reset
	input wire mclk,
	input wire rst_n,
	// Register port
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// External pins, two groups of eight
	input wire [7:0] ext_pins_a,
	input wire [7:0] ext_pins_b,
	// Peripheral flags and enables, vectors 2..13
	input wire [NVEC-1:0] periph_flag,
	input wire [NVEC-1:0] periph_en,
	input wire [NVEC-1:0] periph_clear,
	// CPU core side
	input wire insn_boundary,
	input wire trap_insn,
	input wire return_from_isr,
	input wire halt_req,
	input wire wait_req,
	input wire [15:0] program_counter,
	input wire [7:0] cpu_x,
	input wire [7:0] cpu_a,
	input wire stack_valid,
	input wire [7:0] stack_rdata,
	output reg stack_push,
	output reg stack_pop,
	output reg [7:0] stack_wdata,
	output reg pc_load,
	output reg [15:0] pc_vector,
	output reg cpu_stall,
	output reg cpu_halted,
	output reg cpu_waiting,
	output reg [7:0] condition_code_reg
);
	localparam S_RUN = `NPIC_S_RUN;
	localparam S_PUSH = `NPIC_S_PUSH;
	localparam S_VEC = `NPIC_S_VEC;
	localparam S_POP = `NPIC_S_POP;
	localparam S_HALT = `NPIC_S_HALT;

	reg [2:0] state_q;
	reg [2:0] cnt_q;
	reg [2*NVEC-1:0] vector_sw_priority_regs;
	reg [7:0] ext_irq_sense_regs;
	reg [7:0] grp_en_a_q;
	reg [7:0] grp_en_b_q;
	reg [NVEC-1:0] pend_q;
	reg [15:0] pin_s1_q;
	reg [15:0] pin_s2_q;
	reg [1:0] grp_prev_q;
	reg trap_q;
	reg [3:0] win_q;
	reg win_trap_q;
	reg win_reset_q;
	reg [1:0] win_prio_q;
	integer i;
	integer j;
	integer k;
	integer m;

	// Rank of a priority code: 0 lowest, 3 mask-all
	function [1:0] rank;
		input [1:0] code;
		begin
			case (code)
				`NPIC_LVL0: rank = 2'd0;
				`NPIC_LVL1: rank = 2'd1;
				`NPIC_LVL2: rank = 2'd2;
				default: rank = 2'd3;
			endcase
		end
	endfunction

	wire [1:0] cur_code = {condition_code_reg[`NPIC_CC_HI], condition_code_reg[`NPIC_CC_LO]};
	wire [1:0] cur_rank = rank(cur_code);

	// Group NAND of enabled synchronised pins
	wire grp_a_lvl = ~&(pin_s2_q[7:0] | ~grp_en_a_q);
	wire grp_b_lvl = ~&(pin_s2_q[15:8] | ~grp_en_b_q);
	wire [1:0] grp_lvl = {grp_b_lvl, grp_a_lvl};

	// Live request per vector
	reg [NVEC-1:0] req_raw;
	always @* begin
		req_raw = periph_flag & periph_en;
		req_raw[0] = 1'b0;
		req_raw[1] = 1'b0;
	end

	// Eligible and arbitration over software then hardware priority
	reg [NVEC-1:0] elig;
	reg [3:0] best_idx;
	reg [1:0] best_rank;
	reg best_any;
	reg [1:0] r;
	always @* begin
		best_idx = 4'h0;
		best_rank = 2'd0;
		best_any = 1'b0;
		r = 2'd0;
		for (i = 0; i < NVEC; i = i + 1) begin
			r = rank(vector_sw_priority_regs[2*i +: 2]);
			elig[i] = pend_q[i] && (r > cur_rank);
			// Lower index wins ties: unique hardware order
			if (elig[i] && (!best_any || r > best_rank)) begin
				best_idx = i[3:0];
				best_rank = r;
				best_any = 1'b1;
			end
		end
	end

	// Halt wake: externals and designated peripherals
	wire [NVEC-1:0] halt_wake_mask = 14'b00000000101011;
	wire halt_wake = |(pend_q & halt_wake_mask) || trap_insn;

	// Pin synchroniser; both stages reset to the idle high pin level
	// so that no false group edge can follow reset
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_q <= 16'hffff;
			pin_s2_q <= 16'hffff;
			grp_prev_q <= 2'b00;
		end else begin
			pin_s1_q <= {ext_pins_b, ext_pins_a};
			pin_s2_q <= pin_s1_q;
			grp_prev_q <= grp_lvl;
		end
	end

	// Pending latches; a new request wins over the service clear, periph_clear wins over a peripheral request
	reg [NVEC-1:0] pend_d;
	reg [1:0] ext_hit;
	always @* begin
		pend_d = pend_q;
		ext_hit[0] = ext_irq_sense_regs[0] ? (grp_lvl[0] & ~grp_prev_q[0]) : grp_lvl[0];
		ext_hit[1] = ext_irq_sense_regs[1] ? (grp_lvl[1] & ~grp_prev_q[1]) : grp_lvl[1];
		if (state_q == S_VEC && !win_trap_q && !win_reset_q)
			pend_d[win_q] = 1'b0;
		pend_d = pend_d & ~periph_clear;
		for (j = 2; j < NVEC; j = j + 1)
			if (!periph_clear[j])
				pend_d[j] = pend_d[j] | req_raw[j];
		// A level-mode group follows its NAND output and never latches
		for (j = 0; j < 2; j = j + 1) begin
			if (!ext_irq_sense_regs[j])
				pend_d[j] = ext_hit[j];
			else if (ext_hit[j])
				pend_d[j] = 1'b1;
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			pend_q <= {NVEC{1'b0}};
		else
			pend_q <= pend_d;
	end

	// Software registers; level-0 writes leave a field alone
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			vector_sw_priority_regs <= {NVEC{2'b11}};
			ext_irq_sense_regs <= 8'h00;
			grp_en_a_q <= 8'h00;
			grp_en_b_q <= 8'h00;
		end else if (reg_wr) begin
			case (reg_addr)
				`NPIC_ADDR_PRIO0, `NPIC_ADDR_PRIO1, `NPIC_ADDR_PRIO2, `NPIC_ADDR_PRIO3: begin
					for (k = 0; k < 4; k = k + 1)
						if ((reg_addr[1:0] * 4 + k) < NVEC &&
							reg_wdata[2*k +: 2] != `NPIC_LVL0)
							vector_sw_priority_regs[2*(reg_addr[1:0]*4+k) +: 2] <=
								reg_wdata[2*k +: 2];
				end
				`NPIC_ADDR_SENSE: ext_irq_sense_regs <= reg_wdata;
				`NPIC_ADDR_GRPEN: grp_en_a_q <= reg_wdata;
				`NPIC_ADDR_PEN_LO: grp_en_b_q <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Register read data, one cycle later
	reg [7:0] rd_d;
	reg [4:0] fidx;
	always @* begin
		rd_d = 8'h00;
		fidx = 5'd0;
		case (reg_addr)
			`NPIC_ADDR_PRIO0, `NPIC_ADDR_PRIO1, `NPIC_ADDR_PRIO2, `NPIC_ADDR_PRIO3: begin
				// Fields above the last vector read as mask-all
				for (m = 0; m < 4; m = m + 1) begin
					fidx = {1'b0, reg_addr[1:0], 2'b00} + m[4:0];
					rd_d[2*m +: 2] = (fidx < NVEC) ? vector_sw_priority_regs[2*fidx +: 2] : 2'b11;
				end
			end
			`NPIC_ADDR_SENSE: rd_d = ext_irq_sense_regs;
			`NPIC_ADDR_GRPEN: rd_d = grp_en_a_q;
			`NPIC_ADDR_PEN_LO: rd_d = grp_en_b_q;
			`NPIC_ADDR_PEN_HI: rd_d = pend_q[7:0];
			`NPIC_ADDR_CC: rd_d = condition_code_reg;
			`NPIC_ADDR_STAT: rd_d = {pend_q[13:8], cpu_halted, cpu_waiting};
			default: rd_d = 8'h00;
		endcase
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= reg_rd ? rd_d : 8'h00;
	end

	// Stack byte for each push step
	reg [7:0] push_byte;
	always @* begin
		case (cnt_q)
			3'd0: push_byte = program_counter[7:0];
			3'd1: push_byte = program_counter[15:8];
			3'd2: push_byte = cpu_x;
			3'd3: push_byte = cpu_a;
			default: push_byte = condition_code_reg;
		endcase
	end

	// Service sequencer
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= S_VEC;
			cnt_q <= 3'd0;
			trap_q <= 1'b0;
			win_q <= 4'h0;
			win_trap_q <= 1'b0;
			win_reset_q <= 1'b1;
			win_prio_q <= `NPIC_LVL3;
			condition_code_reg <= `NPIC_CC_RST;
			stack_push <= 1'b0;
			stack_pop <= 1'b0;
			stack_wdata <= 8'h00;
			pc_load <= 1'b0;
			pc_vector <= 16'h0000;
			cpu_stall <= 1'b1;
			cpu_halted <= 1'b0;
			cpu_waiting <= 1'b0;
		end else begin
			stack_push <= 1'b0;
			stack_pop <= 1'b0;
			pc_load <= 1'b0;
			// A trap seen while busy waits in trap_q for the next boundary
			if (trap_insn)
				trap_q <= 1'b1;
			// Software sets the level here; the vector load and return override it
			if (reg_wr && reg_addr == `NPIC_ADDR_CC)
				condition_code_reg <= reg_wdata;
			case (state_q)
				S_RUN: begin
					if (insn_boundary) begin
						if (trap_insn || trap_q) begin
							win_trap_q <= 1'b1;
							win_reset_q <= 1'b0;
							win_prio_q <= `NPIC_LVL3;
							trap_q <= 1'b0;
							state_q <= S_PUSH;
							cnt_q <= 3'd0;
							cpu_stall <= 1'b1;
						end else if (best_any) begin
							win_trap_q <= 1'b0;
							win_reset_q <= 1'b0;
							win_q <= best_idx;
							win_prio_q <= vector_sw_priority_regs[2*best_idx +: 2];
							state_q <= S_PUSH;
							cnt_q <= 3'd0;
							cpu_stall <= 1'b1;
						end else if (return_from_isr) begin
							state_q <= S_POP;
							cnt_q <= 3'd0;
							cpu_stall <= 1'b1;
						end else if (halt_req || wait_req) begin
							state_q <= S_HALT;
							cpu_halted <= halt_req;
							cpu_waiting <= ~halt_req;
							cpu_stall <= 1'b1;
						end
					end
				end
				S_PUSH: begin
					stack_push <= 1'b1;
					stack_wdata <= push_byte;
					if (cnt_q == `NPIC_STACK_BYTES - 3'd1)
						state_q <= S_VEC;
					else
						cnt_q <= cnt_q + 3'd1;
				end
				S_VEC: begin
					condition_code_reg[`NPIC_CC_HI] <= win_prio_q[1];
					condition_code_reg[`NPIC_CC_LO] <= win_prio_q[0];
					pc_load <= 1'b1;
					if (win_reset_q)
						pc_vector <= `NPIC_VEC_RESET;
					else if (win_trap_q)
						pc_vector <= `NPIC_VEC_TRAP;
					else
						pc_vector <= `NPIC_VEC_TOP - {11'h000, win_q, 1'b0};
					win_reset_q <= 1'b0;
					state_q <= S_RUN;
					cpu_stall <= 1'b0;
				end
				S_POP: begin
					// CC comes back first; remaining bytes are the core's
					if (cnt_q == 3'd0) begin
						stack_pop <= 1'b1;
						cnt_q <= 3'd1;
					end else if (stack_valid) begin
						condition_code_reg <= stack_rdata;
						state_q <= S_RUN;
						cpu_stall <= 1'b0;
					end
				end
				S_HALT: begin
					// Wait wakes on any eligible source, halt only on designated ones
					if (cpu_waiting ? (best_any || trap_q || trap_insn) : halt_wake) begin
						cpu_halted <= 1'b0;
						cpu_waiting <= 1'b0;
						state_q <= S_RUN;
						cpu_stall <= 1'b0;
					end
				end
				default: state_q <= S_RUN;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- hw/npic_regs.vh
// Constants of the nested priority interrupt controller
// How it works
// - Priority codes: level0=10, level1=01, level2=00, level3=11 masks all maskable.
// - Service starts only at an instruction boundary, after the current instruction.
// - Maskable and trap entry push PC, X, A and CC onto the stack.
// - Entry loads CC priority bits from the serviced vector's stored priority.
// - PC loads from a fixed top-of-memory vector ordered by hardware priority.
// - Return pops the saved registers, restoring the interrupted priority bits.
// - Highest software priority wins; ties go to highest hardware priority.
// - Hardware priorities are unique, so exactly one winner always results.
// - Unserviced requests, except level-mode externals and peripherals dropped by periph_clear, stay latched until they become the highest eligible.
// - Reset and trap ignore the mask and set level 3; reset skips stacking.
// - Reset and trap wake the processor from halt.
// - The trap instruction raises the trap source with normal stacking and vectoring.
// - Maskable requests need enable set and priority strictly above current level.
// - External requests wake the processor from halt.
// - Each external pin group's sensitivity is chosen by one bit of the sense register.
// - Edge external requests latch and clear automatically on service entry.
// - Several pins of one vector at once give a single service.
// - Pins enabled together on one vector are NANDed; one low pin masks others.
// - Peripheral request is flag AND enable.
// - The peripheral clear sequence drops the request latch, losing pending service.
// - Four software nesting levels and up to sixteen hardware vectors.
// - Any eligible source or trap wakes from wait; only designated sources wake from halt.
// - Writing the level-0 code into a priority field keeps the old value.
`ifndef NPIC_REGS_VH
`define NPIC_REGS_VH
// Register offsets on the plain port
`define NPIC_ADDR_PRIO0 4'h0
`define NPIC_ADDR_PRIO1 4'h1
`define NPIC_ADDR_PRIO2 4'h2
`define NPIC_ADDR_PRIO3 4'h3
`define NPIC_ADDR_SENSE 4'h4
`define NPIC_ADDR_GRPEN 4'h5
`define NPIC_ADDR_PEN_LO 4'h6
`define NPIC_ADDR_PEN_HI 4'h7
`define NPIC_ADDR_CC 4'h8
`define NPIC_ADDR_STAT 4'h9
// Priority codes {high,low}
`define NPIC_LVL0 2'b10
`define NPIC_LVL1 2'b01
`define NPIC_LVL2 2'b00
`define NPIC_LVL3 2'b11
// Reset values
`define NPIC_PRIO_RST 8'hff
`define NPIC_CC_RST 8'hea
// Condition code field positions
`define NPIC_CC_HI 5
`define NPIC_CC_LO 3
// Vector addresses
`define NPIC_VEC_RESET 16'hfffe
`define NPIC_VEC_TRAP 16'hfffc
`define NPIC_VEC_TOP 16'hfffa
// Stack save order: PC lo, PC hi, X, A, CC
`define NPIC_STACK_BYTES 3'h5
// Sequencer states
`define NPIC_S_RUN 3'h0
`define NPIC_S_PUSH 3'h1
`define NPIC_S_VEC 3'h2
`define NPIC_S_POP 3'h3
`define NPIC_S_HALT 3'h4
`endif
